// File: pkg/rpb_pkg.sv
// Register map, field layout and timing constants of the reference profile bank
`default_nettype none
package rpb_pkg;
    typedef logic [13:0] rpb_idx_t;

    localparam int ADR_W = 16;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;

    // Byte offsets within a multi-byte field
    localparam rpb_idx_t B1 = 14'h0001;
    localparam rpb_idx_t B2 = 14'h0002;
    localparam rpb_idx_t B3 = 14'h0003;
    localparam rpb_idx_t B4 = 14'h0004;

    // Register indices; byte address is four times the index
    localparam rpb_idx_t IX_PRIO_P1     = 14'h0632;
    localparam rpb_idx_t IX_FB_INT_P1   = 14'h0654;
    localparam rpb_idx_t IX_FRAC_NUM_P1 = 14'h0658;
    localparam rpb_idx_t IX_FRAC_DEN_P1 = 14'h0659;
    localparam rpb_idx_t IX_PH_THR_P1   = 14'h065b;
    localparam rpb_idx_t IX_PH_FILL_P1  = 14'h065d;
    localparam rpb_idx_t IX_PH_DRAIN_P1 = 14'h065e;
    localparam rpb_idx_t IX_FQ_THR_P1   = 14'h065f;
    localparam rpb_idx_t IX_FQ_FILL_P1  = 14'h0662;
    localparam rpb_idx_t IX_FQ_DRAIN_P1 = 14'h0663;
    localparam rpb_idx_t IX_PRIO_P2     = 14'h0680;
    localparam rpb_idx_t IX_PERIOD_P2   = 14'h0681;
    localparam rpb_idx_t IX_PAD_P2      = 14'h0686;
    localparam rpb_idx_t IX_INNER_P2    = 14'h0688;
    localparam rpb_idx_t IX_OUTER_P2    = 14'h068b;
    localparam rpb_idx_t IX_VALID_P2    = 14'h068e;
    localparam rpb_idx_t IX_REDET_P2    = 14'h0690;
    localparam rpb_idx_t IX_A0_LIN_P2   = 14'h0692;
    localparam rpb_idx_t IX_A1_EXP_P2   = 14'h0694;
    localparam rpb_idx_t IX_B0_LIN_P2   = 14'h0695;
    localparam rpb_idx_t IX_B1_EXP_P2   = 14'h0697;
    localparam rpb_idx_t IX_G0_LIN_P2   = 14'h0698;
    localparam rpb_idx_t IX_G1_EXP_P2   = 14'h069a;
    localparam rpb_idx_t IX_D0_LIN_P2   = 14'h069b;
    localparam rpb_idx_t IX_D1_EXP_P2   = 14'h069c;
    localparam rpb_idx_t IX_A3_EXP_P2   = 14'h069d;
    localparam rpb_idx_t IX_LO          = IX_PRIO_P1;
    localparam rpb_idx_t IX_HI          = IX_A3_EXP_P2;

    // Writable bit masks of fully used, unused and partly used bytes
    localparam logic [7:0] MASK_FULL  = 8'hff;
    localparam logic [7:0] MASK_NONE  = 8'h00;
    localparam logic [7:0] MASK_PRIO  = 8'hbf;
    localparam logic [7:0] MASK_NIB   = 8'h0f;
    localparam logic [7:0] MASK_FRAC  = 8'hf3;
    localparam logic [7:0] MASK_LOW6  = 8'h3f;
    localparam logic [7:0] MASK_LOW7  = 8'h7f;

    // Priority byte layout
    localparam int PRIO_SCALE_BIT = 7;
    localparam int PRIO_PROM_LSB  = 3;
    localparam int PRIO_SEL_LSB   = 0;

    // Widths
    localparam int FB_INT_W  = 20;
    localparam int FRAC_W    = 10;
    localparam int PH_THR_W  = 16;
    localparam int PH_PS_W   = 26;
    localparam int FQ_THR_W  = 24;
    localparam int PRIO_W    = 3;
    localparam int PERIOD_W  = 40;
    localparam int TOL_W     = 20;
    localparam int TIMER_W   = 16;

    localparam logic [FB_INT_W:0] FB_INT_MIN  = 21'h000007;
    localparam logic [9:0]        PS_PER_NS   = 10'h3e8;

    // Millisecond timebase for the validation and redetect timers
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_PS         = 1000000000;
    localparam int MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
endpackage
`default_nettype wire

// File: hw/rpb_bank.sv
// Reference profile register bank with a classic Wishbone slave
// How it works
// - Feedback divide ratio output is the programmed integer field plus one.
// - Numerator and denominator are assembled from their split byte fields.
// - Profile-one phase threshold unit comes from its priority byte bit seven.
// - Scale bit zero means picoseconds, one means nanoseconds.
// - Frequency lock threshold is 24 bits of picoseconds, low byte first.
// - Phase lock fill and drain rates are separate full bytes.
// - Frequency lock fill and drain rates are separate full bytes.
// - Selection priority ranks the profile's reference against the others.
// - Promoted priority applies only while the reference is active.
// - Nominal period is 40 bits of femtoseconds, least significant byte first.
// - Inner and outer tolerance are 20 bits, two bytes plus a nibble.
// - Validation and redetect timers count 16-bit milliseconds.
// - Each coefficient is a linear fraction times two to an exponent.
// - Coefficient linear and exponent fields have their documented widths.
// - Alpha-2 exponent bit two and delta-1 exponent bit zero straddle bytes.
`default_nettype none
module rpb_bank
    import rpb_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADR_W-1:0]      wb_adr_i,
    input  wire logic [DAT_W-1:0]      wb_dat_i,
    input  wire logic [SEL_W-1:0]      wb_sel_i,
    output logic      [DAT_W-1:0]      wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  ref_active_p2,
    output logic      [FB_INT_W:0]     fb_int_ratio_p1,
    output logic                       fb_int_too_small_p1,
    output logic      [FRAC_W-1:0]     frac_num_p1,
    output logic      [FRAC_W-1:0]     frac_den_p1,
    output logic      [PH_PS_W-1:0]    ph_thr_ps_p1,
    output logic      [7:0]            ph_fill_p1,
    output logic      [7:0]            ph_drain_p1,
    output logic      [FQ_THR_W-1:0]   fq_thr_ps_p1,
    output logic      [7:0]            fq_fill_p1,
    output logic      [7:0]            fq_drain_p1,
    output logic                       ph_scale_ns_p2,
    output logic      [PRIO_W-1:0]     sel_prio_p2,
    output logic      [PRIO_W-1:0]     prom_prio_p2,
    output logic      [PRIO_W-1:0]     eff_prio_p2,
    output logic      [PERIOD_W-1:0]   period_fs_p2,
    output logic      [TOL_W-1:0]      inner_tol_p2,
    output logic      [TOL_W-1:0]      outer_tol_p2,
    output logic      [TIMER_W-1:0]    valid_ms_p2,
    output logic      [TIMER_W-1:0]    redet_ms_p2,
    output logic                       ms_tick,
    output logic      [15:0]           a0_lin_p2,
    output logic      [5:0]            a1_exp_p2,
    output logic      [2:0]            a2_exp_p2,
    output logic      [3:0]            a3_exp_p2,
    output logic      [16:0]           b0_lin_p2,
    output logic      [4:0]            b1_exp_p2,
    output logic      [16:0]           g0_lin_p2,
    output logic      [4:0]            g1_exp_p2,
    output logic      [14:0]           d0_lin_p2,
    output logic      [4:0]            d1_exp_p2
);

    // Writable bits of each byte; anything not listed is unused
    function automatic logic [7:0] byte_mask(input rpb_idx_t ix);
        logic [7:0] m;
        m = MASK_NONE;
        if (ix == IX_PRIO_P1 || ix == IX_PRIO_P2) begin
            m = MASK_PRIO;
        end else if (ix == IX_FB_INT_P1 + B2 || ix == IX_INNER_P2 + B2
                     || ix == IX_OUTER_P2 + B2) begin
            m = MASK_NIB;
        end else if (ix == IX_FRAC_DEN_P1) begin
            m = MASK_FRAC;
        end else if (ix == IX_FRAC_DEN_P1 + B1 || ix == IX_G1_EXP_P2) begin
            m = MASK_LOW6;
        end else if (ix == IX_B1_EXP_P2) begin
            m = MASK_LOW7;
        end else if ((ix >= IX_FB_INT_P1 && ix <= IX_FB_INT_P1 + B1)
                     || (ix >= IX_FRAC_NUM_P1 && ix <= IX_FQ_DRAIN_P1)
                     || (ix >= IX_PERIOD_P2 && ix < IX_PAD_P2)
                     || (ix >= IX_INNER_P2 && ix <= IX_A3_EXP_P2)) begin
            m = MASK_FULL;
        end
        return m;
    endfunction

    // Reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    logic [7:0] bank_reg [IX_LO:IX_HI];
    logic       ack_reg;
    logic [7:0] rdat_reg;

    // Bus decode
    wire logic     req      = wb_cyc_i && wb_stb_i && !ack_reg;
    wire rpb_idx_t idx      = wb_adr_i[ADR_W-1:2];
    wire logic     in_bank  = (idx >= IX_LO) && (idx <= IX_HI);
    wire logic [7:0] wmask  = in_bank ? byte_mask(idx) : MASK_NONE;
    wire logic     wr_en    = req && wb_we_i && wb_sel_i[0] && in_bank;
    // Unused bits and addresses read as zero
    // read masking
    wire logic [7:0] rd_byte = in_bank ? (bank_reg[idx] & wmask) : MASK_NONE;

    // Ack one cycle after the request; dropped the cycle after
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            ack_reg  <= req;
            rdat_reg <= req ? rd_byte : 8'h00;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = {24'h000000, rdat_reg};

    // Writes keep only the used bits, so reserved bits stay zero
    // write masking
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            for (int i = IX_LO; i <= IX_HI; i++) begin
                bank_reg[i] <= 8'h00;
            end
        end else if (wr_en) begin
            bank_reg[idx] <= wb_dat_i[7:0] & wmask;
        end
    end

    // Field assembly from the byte bank
    wire logic [FB_INT_W-1:0] fb_int = {
        bank_reg[IX_FB_INT_P1 + B2][3:0],
        bank_reg[IX_FB_INT_P1 + B1],
        bank_reg[IX_FB_INT_P1]
    };

    wire logic [FRAC_W-1:0] num = {
        bank_reg[IX_FRAC_DEN_P1][1:0],
        bank_reg[IX_FRAC_NUM_P1]
    };
    wire logic [FRAC_W-1:0] den = {
        bank_reg[IX_FRAC_DEN_P1 + B1][5:0],
        bank_reg[IX_FRAC_DEN_P1][7:4]
    };

    wire logic [PH_THR_W-1:0] ph_thr = {
        bank_reg[IX_PH_THR_P1 + B1],
        bank_reg[IX_PH_THR_P1]
    };

    wire logic scale_p1 = bank_reg[IX_PRIO_P1][PRIO_SCALE_BIT];

    // Both factors widened first so the product keeps all its bits
    wire logic [PH_PS_W-1:0] ph_thr_wide = PH_PS_W'(ph_thr);
    wire logic [PH_PS_W-1:0] ps_per_ns_wide = PH_PS_W'(PS_PER_NS);

    wire logic [PH_PS_W-1:0] ph_ps = scale_p1 ? ph_thr_wide * ps_per_ns_wide
                                              : ph_thr_wide;

    wire logic [7:0] prio2 = bank_reg[IX_PRIO_P2];
    wire logic [PRIO_W-1:0] sel2  = prio2[PRIO_SEL_LSB +: PRIO_W];
    wire logic [PRIO_W-1:0] prom2 = prio2[PRIO_PROM_LSB +: PRIO_W];

    // Millisecond tick shared by the validation and redetect timers
    logic [31:0] ms_cnt_reg;
    wire  logic  ms_wrap = (ms_cnt_reg == 32'(MS_CYCLES_P - 1));

    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ms_cnt_reg <= 32'h00000000;
            ms_tick    <= 1'b0;
        end else begin
            ms_cnt_reg <= ms_wrap ? 32'h00000000 : ms_cnt_reg + 32'h00000001;
            ms_tick    <= ms_wrap;
        end
    end

    // Profile one outputs, all registered
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            fb_int_ratio_p1     <= '0;
            fb_int_too_small_p1 <= 1'b0;
            frac_num_p1         <= '0;
            frac_den_p1         <= '0;
            ph_thr_ps_p1        <= '0;
            ph_fill_p1          <= 8'h00;
            ph_drain_p1         <= 8'h00;
            fq_thr_ps_p1        <= '0;
            fq_fill_p1          <= 8'h00;
            fq_drain_p1         <= 8'h00;
        end else begin
            fb_int_ratio_p1     <= {1'b0, fb_int} + 21'h000001;

            // flag a setting below the minimum
            fb_int_too_small_p1 <= ({1'b0, fb_int} < FB_INT_MIN);

            frac_num_p1         <= num;
            frac_den_p1         <= den;
            ph_thr_ps_p1        <= ph_ps;

            ph_fill_p1          <= bank_reg[IX_PH_FILL_P1];
            ph_drain_p1         <= bank_reg[IX_PH_DRAIN_P1];

            fq_thr_ps_p1        <= {
                bank_reg[IX_FQ_THR_P1 + B2],
                bank_reg[IX_FQ_THR_P1 + B1],
                bank_reg[IX_FQ_THR_P1]
            };

            fq_fill_p1          <= bank_reg[IX_FQ_FILL_P1];
            fq_drain_p1         <= bank_reg[IX_FQ_DRAIN_P1];
        end
    end

    // Profile two outputs; the pad bytes after the period are never stored
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ph_scale_ns_p2 <= 1'b0;
            sel_prio_p2    <= '0;
            prom_prio_p2   <= '0;
            eff_prio_p2    <= '0;
            period_fs_p2   <= '0;
            inner_tol_p2   <= '0;
            outer_tol_p2   <= '0;
            valid_ms_p2    <= '0;
            redet_ms_p2    <= '0;
        end else begin
            ph_scale_ns_p2 <= prio2[PRIO_SCALE_BIT];

            sel_prio_p2    <= sel2;
            prom_prio_p2   <= prom2;

            eff_prio_p2    <= ref_active_p2 ? prom2 : sel2;

            period_fs_p2   <= {
                bank_reg[IX_PERIOD_P2 + B4],
                bank_reg[IX_PERIOD_P2 + B3],
                bank_reg[IX_PERIOD_P2 + B2],
                bank_reg[IX_PERIOD_P2 + B1],
                bank_reg[IX_PERIOD_P2]
            };

            inner_tol_p2   <= {
                bank_reg[IX_INNER_P2 + B2][3:0],
                bank_reg[IX_INNER_P2 + B1],
                bank_reg[IX_INNER_P2]
            };
            outer_tol_p2   <= {
                bank_reg[IX_OUTER_P2 + B2][3:0],
                bank_reg[IX_OUTER_P2 + B1],
                bank_reg[IX_OUTER_P2]
            };

            valid_ms_p2    <= {
                bank_reg[IX_VALID_P2 + B1],
                bank_reg[IX_VALID_P2]
            };
            redet_ms_p2    <= {
                bank_reg[IX_REDET_P2 + B1],
                bank_reg[IX_REDET_P2]
            };
        end
    end

    // Loop filter coefficients leave as linear and exponent pairs, so the
    // filter applies the two-to-the-exponent scaling as a cheap shift
    always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            a0_lin_p2 <= '0;
            a1_exp_p2 <= '0;
            a2_exp_p2 <= '0;
            a3_exp_p2 <= '0;
            b0_lin_p2 <= '0;
            b1_exp_p2 <= '0;
            g0_lin_p2 <= '0;
            g1_exp_p2 <= '0;
            d0_lin_p2 <= '0;
            d1_exp_p2 <= '0;
        end else begin
            a0_lin_p2 <= {
                bank_reg[IX_A0_LIN_P2 + B1],
                bank_reg[IX_A0_LIN_P2]
            };
            a1_exp_p2 <= bank_reg[IX_A1_EXP_P2][5:0];

            // alpha-2 bit two from next byte
            a2_exp_p2 <= {
                bank_reg[IX_B0_LIN_P2][0],
                bank_reg[IX_A1_EXP_P2][7:6]
            };
            a3_exp_p2 <= bank_reg[IX_A3_EXP_P2][7:4];

            b0_lin_p2 <= {
                bank_reg[IX_B1_EXP_P2][1:0],
                bank_reg[IX_B0_LIN_P2 + B1],
                bank_reg[IX_B0_LIN_P2][7:1]
            };
            b1_exp_p2 <= bank_reg[IX_B1_EXP_P2][6:2];

            g0_lin_p2 <= {
                bank_reg[IX_G1_EXP_P2][0],
                bank_reg[IX_G0_LIN_P2 + B1],
                bank_reg[IX_G0_LIN_P2]
            };
            g1_exp_p2 <= bank_reg[IX_G1_EXP_P2][5:1];

            d0_lin_p2 <= {
                bank_reg[IX_D1_EXP_P2][6:0],
                bank_reg[IX_D0_LIN_P2]
            };

            // delta-1 bit zero from lower byte
            d1_exp_p2 <= {
                bank_reg[IX_A3_EXP_P2][3:0],
                bank_reg[IX_D1_EXP_P2][7]
            };
        end
    end

endmodule
`default_nettype wire

// File: dv/rpb_bank_asserts.sv
// Concurrent checks on the ports of the reference profile bank
`default_nettype none
module rpb_bank_asserts
    import rpb_pkg::*;
#(
    parameter int MS_CYCLES_P = 8
) (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic [DAT_W-1:0]    wb_dat_o,
    input wire logic                wb_ack_o,
    input wire logic                ref_active_p2,
    input wire logic [FB_INT_W:0]   fb_int_ratio_p1,
    input wire logic                fb_int_too_small_p1,
    input wire logic [PH_PS_W-1:0]  ph_thr_ps_p1,
    input wire logic [PRIO_W-1:0]   sel_prio_p2,
    input wire logic [PRIO_W-1:0]   prom_prio_p2,
    input wire logic [PRIO_W-1:0]   eff_prio_p2,
    input wire logic                ms_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] tick_gap_reg;
    logic        tick_seen_reg;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Gap counter only trusted after the first tick, since reset sync skews phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_gap_reg  <= 32'h0;
            tick_seen_reg <= 1'b0;
        end else begin
            tick_gap_reg  <= ms_tick ? 32'h0 : tick_gap_reg + 32'h1;
            tick_seen_reg <= tick_seen_reg | ms_tick;
        end
    end
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_pulse: assert property (s_taken |=> s_answer)
        else $error("ack not a single pulse one cycle after request");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_upper_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("unused read data bits not zero");
    chk_ratio_flag: assert property (fb_int_ratio_p1 != 21'h0 |->
        fb_int_too_small_p1 == (fb_int_ratio_p1 < 21'h8))
        else $error("divide ratio and small flag disagree");
    chk_eff_select: assert property ($stable(sel_prio_p2) && $stable(prom_prio_p2) |->
        eff_prio_p2 == ($past(ref_active_p2) ? prom_prio_p2 : sel_prio_p2))
        else $error("effective priority wrong for active state");
    chk_ms_period: assert property (tick_seen_reg |->
        ms_tick == (tick_gap_reg == MS_CYCLES_P - 1))
        else $error("millisecond tick spacing wrong");
    chk_ph_unit: assert property ((ph_thr_ps_p1 < 26'h0010000) ||
        (ph_thr_ps_p1 % 26'h00003e8 == 26'h0))
        else $error("phase threshold neither raw ps nor ns scaled");
endmodule
bind rpb_bank rpb_bank_asserts #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_active_p2(ref_active_p2),
    .fb_int_ratio_p1(fb_int_ratio_p1), .fb_int_too_small_p1(fb_int_too_small_p1),
    .ph_thr_ps_p1(ph_thr_ps_p1), .sel_prio_p2(sel_prio_p2), .prom_prio_p2(prom_prio_p2),
    .eff_prio_p2(eff_prio_p2), .ms_tick(ms_tick));
`default_nettype wire

// File: dv/rpb_bank_tb.sv
// Self-checking bench for the reference profile register bank
`default_nettype none
module rpb_bank_tb
    import rpb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic                ref_active_p2, fb_int_too_small_p1, ph_scale_ns_p2, ms_tick;
    logic [ADR_W-1:0]    wb_adr_i;
    logic [DAT_W-1:0]    wb_dat_i, wb_dat_o;
    logic [SEL_W-1:0]    wb_sel_i;
    logic [FB_INT_W:0]   fb_int_ratio_p1;
    logic [FRAC_W-1:0]   frac_num_p1, frac_den_p1;
    logic [PH_PS_W-1:0]  ph_thr_ps_p1;
    logic [7:0]          ph_fill_p1, ph_drain_p1, fq_fill_p1, fq_drain_p1;
    logic [FQ_THR_W-1:0] fq_thr_ps_p1;
    logic [PRIO_W-1:0]   sel_prio_p2, prom_prio_p2, eff_prio_p2;
    logic [PERIOD_W-1:0] period_fs_p2;
    logic [TOL_W-1:0]    inner_tol_p2, outer_tol_p2;
    logic [TIMER_W-1:0]  valid_ms_p2, redet_ms_p2, a0_lin_p2;
    logic [16:0]         b0_lin_p2, g0_lin_p2;
    logic [14:0]         d0_lin_p2;
    logic [5:0]          a1_exp_p2;
    logic [4:0]          b1_exp_p2, g1_exp_p2, d1_exp_p2;
    logic [3:0]          a3_exp_p2;
    logic [2:0]          a2_exp_p2;
    int                  fails, compares, cycles;

    // Short millisecond count keeps tick spacing visible in a brief run
    rpb_bank #(.MS_CYCLES_P(8)) dut (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    // One classic cycle; the wait is bounded so a dead slave cannot hang the run
    task automatic bus(input logic we, input rpb_idx_t ix, input logic [7:0] d,
                       input logic [7:0] e);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {ix, 2'b00};
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        chk("ack", 48'h1, {47'h0, wb_ack_o});
        if (!we)
            chk("rdata", {16'h0, 24'h0, e}, {16'h0, wb_dat_o});
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic w(input rpb_idx_t ix, input logic [7:0] d);
        bus(1'b1, ix, d, 8'h00);
    endtask

    task automatic r(input rpb_idx_t ix, input logic [7:0] e);
        bus(1'b0, ix, 8'h00, e);
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic tend(input string nm);
        $display("Test %s done, mismatches so far %0d", nm, fails);
    endtask

    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_dat_i = '0;
        wb_sel_i = 4'hf;
        ref_active_p2 = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("ratio", 48'h1, fb_int_ratio_p1);
        chk("small", 48'h1, fb_int_too_small_p1);
        r(IX_FB_INT_P1, 8'h00);
        tend("reset");
        w(IX_FB_INT_P1, 8'h06);
        settle();
        chk("ratio", 48'h7, fb_int_ratio_p1);
        chk("small", 48'h1, fb_int_too_small_p1);
        w(IX_FB_INT_P1, 8'h07);
        w(IX_FB_INT_P1 + B1, 8'h34);
        w(IX_FB_INT_P1 + B2, 8'hff);
        r(IX_FB_INT_P1 + B2, 8'h0f);
        w(IX_FB_INT_P1 + B3, 8'h77);
        r(IX_FB_INT_P1 + B3, 8'h00);
        settle();
        chk("ratio", 48'hf3408, fb_int_ratio_p1);
        chk("small", 48'h0, fb_int_too_small_p1);
        w(IX_FRAC_NUM_P1, 8'haa);
        w(IX_FRAC_DEN_P1, 8'h5e);
        w(IX_FRAC_DEN_P1 + B1, 8'hc9);
        r(IX_FRAC_DEN_P1, 8'h52);
        r(IX_FRAC_DEN_P1 + B1, 8'h09);
        settle();
        chk("num", 48'h2aa, frac_num_p1);
        chk("den", 48'h095, frac_den_p1);
        tend("dividers");
        w(IX_PH_THR_P1, 8'h34);
        w(IX_PH_THR_P1 + B1, 8'h12);
        settle();
        chk("ph_thr", 48'h1234, ph_thr_ps_p1);
        w(IX_PRIO_P1, 8'hff);
        r(IX_PRIO_P1, 8'hbf);
        settle();
        chk("ph_thr", 48'h1234 * 48'h3e8, ph_thr_ps_p1);
        w(IX_PH_FILL_P1, 8'h11);
        w(IX_PH_DRAIN_P1, 8'h22);
        w(IX_FQ_THR_P1, 8'h01);
        w(IX_FQ_THR_P1 + B1, 8'h02);
        w(IX_FQ_THR_P1 + B2, 8'h03);
        w(IX_FQ_FILL_P1, 8'h44);
        w(IX_FQ_DRAIN_P1, 8'h55);
        settle();
        chk("ph_fill", 48'h11, ph_fill_p1);
        chk("ph_drain", 48'h22, ph_drain_p1);
        chk("fq_thr", 48'h030201, fq_thr_ps_p1);
        chk("fq_fill", 48'h44, fq_fill_p1);
        chk("fq_drain", 48'h55, fq_drain_p1);
        tend("lock");
        w(IX_PRIO_P2, 8'hff);
        r(IX_PRIO_P2, 8'hbf);
        settle();
        chk("scale", 48'h1, ph_scale_ns_p2);
        chk("prom", 48'h7, prom_prio_p2);
        w(IX_PRIO_P2, 8'h0d);
        settle();
        chk("sel", 48'h5, sel_prio_p2);
        chk("eff", 48'h5, eff_prio_p2);
        @(posedge ref_clk);
        ref_active_p2 <= 1'b1;
        settle();
        chk("eff", 48'h1, eff_prio_p2);
        @(posedge ref_clk);
        ref_active_p2 <= 1'b0;
        settle();
        chk("eff", 48'h5, eff_prio_p2);
        tend("priority");
        for (int k = 0; k < 5; k++)
            w(IX_PERIOD_P2 + rpb_idx_t'(k), 8'h10 + 8'(k));
        w(IX_PAD_P2, 8'h00);
        w(IX_PAD_P2 + B1, 8'h00);
        r(IX_PAD_P2, 8'h00);
        r(IX_PAD_P2 + B1, 8'h00);
        w(IX_INNER_P2, 8'h01);
        w(IX_INNER_P2 + B1, 8'h02);
        w(IX_INNER_P2 + B2, 8'hff);
        w(IX_OUTER_P2, 8'h03);
        w(IX_OUTER_P2 + B1, 8'h04);
        w(IX_OUTER_P2 + B2, 8'hf5);
        w(IX_VALID_P2, 8'h78);
        w(IX_VALID_P2 + B1, 8'h56);
        w(IX_REDET_P2, 8'hbc);
        w(IX_REDET_P2 + B1, 8'h9a);
        settle();
        chk("period", 48'h1413121110, period_fs_p2);
        chk("inner", 48'hf0201, inner_tol_p2);
        chk("outer", 48'h50403, outer_tol_p2);
        chk("valid", 48'h5678, valid_ms_p2);
        chk("redet", 48'h9abc, redet_ms_p2);
        tend("period");
        w(IX_A0_LIN_P2, 8'h01);
        w(IX_A0_LIN_P2 + B1, 8'h80);
        w(IX_A1_EXP_P2, 8'hc5);
        w(IX_B0_LIN_P2, 8'h03);
        w(IX_B0_LIN_P2 + B1, 8'hff);
        w(IX_B1_EXP_P2, 8'hff);
        r(IX_B1_EXP_P2, 8'h7f);
        w(IX_G0_LIN_P2, 8'haa);
        w(IX_G0_LIN_P2 + B1, 8'hbb);
        w(IX_G1_EXP_P2, 8'hff);
        r(IX_G1_EXP_P2, 8'h3f);
        w(IX_D0_LIN_P2, 8'hcc);
        w(IX_D1_EXP_P2, 8'h81);
        w(IX_A3_EXP_P2, 8'ha6);
        settle();
        chk("a0", 48'h8001, a0_lin_p2);
        chk("a1", 48'h05, a1_exp_p2);
        chk("a2", 48'h7, a2_exp_p2);
        chk("b0", 48'h1ff81, b0_lin_p2);
        chk("b1", 48'h1f, b1_exp_p2);
        chk("g0", 48'h1bbaa, g0_lin_p2);
        chk("g1", 48'h1f, g1_exp_p2);
        chk("d0", 48'h01cc, d0_lin_p2);
        chk("d1", 48'h0d, d1_exp_p2);
        chk("a3", 48'ha, a3_exp_p2);
        tend("coefficients");
        w(14'h0670, 8'h5a);
        r(14'h0670, 8'h00);
        r(14'h0700, 8'h00);
        @(posedge ref_clk);
        wb_sel_i <= 4'h0;
        w(IX_PH_FILL_P1, 8'hee);
        @(posedge ref_clk);
        wb_sel_i <= 4'hf;
        r(IX_PH_FILL_P1, 8'h11);
        settle();
        chk("ph_fill", 48'h11, ph_fill_p1);
        tend("refused");
        test_done();
    end
endmodule
`default_nettype wire
